/* logic/rcr_cfg.svh */
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH
// configuration index values
`define RCR_IDX_SEL_PIN_E_A 8'h18
`define RCR_IDX_FAST 8'h19
`define RCR_IDX_FDC 8'h20
`define RCR_IDX_PRT 8'h23
`define RCR_IDX_UA 8'h24
`define RCR_IDX_UB 8'h25
`define RCR_IDX_DMA 8'h26
`define RCR_IDX_PIRQ 8'h27
// writable bit masks, reserved bits clear
`define RCR_MASK_FAST 8'h03
`define RCR_MASK_FDC 8'hFC
`define RCR_MASK_UART 8'hFE
`define RCR_MASK_PIRQ 8'hEF
// strap defaults
`define RCR_DFLT_FDC 8'hFC
`define RCR_DFLT_PRT 8'hDE
`define RCR_DFLT_UA 8'hFE
`define RCR_DFLT_UB 8'hBE
`define RCR_DFLT_DMA 8'h23
`define RCR_DFLT_PIRQ 8'h05
// field positions
`define RCR_FAST_A_BIT 1
`define RCR_FAST_B_BIT 0
`define RCR_SER_FRAME_SMI 4'h2
// timing
`define RCR_CLK_PERIOD_NS 100
`define RCR_SEL_PIN_E_A_PULSE_NS 200
`define RCR_SEL_PIN_E_A_PULSE_CYC ((`RCR_SEL_PIN_E_A_PULSE_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS)
`endif

/* logic/rcr_pkg.sv */
package rcr_pkg;
  typedef enum logic [1:0] {RCR_SRC_NORMAL, RCR_SRC_SPEED, RCR_SRC_MUSIC,
    RCR_SRC_FAST} rcr_clk_src_t;
endpackage : rcr_pkg

/* logic/rcr_regs.sv */
`timescale 1ns/10ps
`include "rcr_cfg.svh"
// How it works
// - registers reached through data port only in extended mode at matching index
// - sel_pin_e_a register bit n picks legacy (0) or sharing (1) for pin n
// - sharing pin pulses low 200 ns per request, otherwise tri-stated
// - serial A fast bit set gives 14.769 MHz, else speed and music select
// - serial B fast bit works the same way
// - floppy decode: bits 7..2 match A9..A4, chip select low, A10 low, A3 low
// - floppy base on 16-byte steps, bits 1..0 fixed zero
// - any base decode is off when its bits 7 and 6 are zero
// - printer decode matches all eight bits against A9..A2
// - printer decode needs A10 low, except extended-capability mode
// - serial A decode matches bits 7..1 with A9..A3, bit 0 zero
// - serial B decode identical to serial A
// - DMA nibbles: 0 none, 1..3 channels A..C; floppy high, printer low
// - printer irq bits 7..5 reappear as read-only config B bits 5..3
// - report code 0 reflects pin, 1..6 irq 7,9,10,11,14,15, 7 irq 5
// - low nibble routes printer irq to pin A..H, others tri-stated
// - serial mode tri-states all pins, irq goes to serial line only
// - serial mode low nibble picks frame; code 2 is the SMI frame
// - after reset defaults load from the strap, zero when strap low
// - flipping the strap reloads defaults; same value does nothing
module rcr_regs
  import rcr_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `RCR_SEL_PIN_E_A_PULSE_CYC
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // configuration port
  input wire logic i_ext_func_mode,
  input wire logic [7:0] i_config_index,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_config_default_strap,
  // host address decode
  input wire logic [10:0] i_addr,
  input wire logic i_chip_select_n,
  input wire logic i_ecp_mode,
  output logic o_floppy_sel,
  output logic o_printer_sel,
  output logic o_serial_a_sel,
  output logic o_serial_b_sel,
  // serial clock selection
  input wire logic i_serial_a_speed_sel,
  input wire logic i_serial_a_music_clk,
  input wire logic i_serial_b_speed_sel,
  input wire logic i_serial_b_music_clk,
  output rcr_clk_src_t o_serial_a_clk_src,
  output rcr_clk_src_t o_serial_b_clk_src,
  // dma routing, one-hot channels A..C
  output logic [2:0] o_floppy_dma_sel,
  output logic [2:0] o_printer_dma_sel,
  // printer interrupt routing
  input wire logic i_printer_irq,
  input wire logic i_serial_interrupt_mode,
  output logic [7:0] o_irq_pin_out,
  output logic [7:0] o_irq_pin_oe,
  output logic o_serial_irq_req,
  output logic [3:0] o_serial_irq_frame,
  output logic [2:0] o_ext_cap_config_b,
  output logic [3:0] o_ext_cap_irq_num
);

  function automatic logic [7:0] dflt(input logic strap, input logic [7:0] val);
    return strap ? val : 8'h00;
  endfunction : dflt

  function automatic logic base_on(input logic [7:0] base);
    return |base[7:6];
  endfunction : base_on

  function automatic logic [2:0] dma_dec(input logic [3:0] code);
    case (code)
      4'h1: return 3'h1;
      4'h2: return 3'h2;
      4'h3: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : dma_dec

  function automatic rcr_clk_src_t clk_src(input logic fast, input logic speed,
                                           input logic music);
    if (fast)
      return RCR_SRC_FAST;
    else if (music)
      return RCR_SRC_MUSIC;
    else if (speed)
      return RCR_SRC_SPEED;
    return RCR_SRC_NORMAL;
  endfunction : clk_src

  logic [7:0] sel_pin_e_a_q, fast_q, fdc_q, prt_q, ua_q, ub_q, dma_q, pirq_q;
  logic init_q, strap_q, load_dflt, wr_ok, irq_prev_q, pulse_start, pin_valid;
  logic [1:0] pulse_cnt_q;
  logic [2:0] pin_idx;

  // reload waits for the first edge so the strap is never caught under reset
  assign load_dflt = !init_q || (i_config_default_strap != strap_q);
  assign wr_ok = i_cfg_wr && i_ext_func_mode;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      init_q <= 1'b0;
      strap_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b1;
      strap_q <= i_config_default_strap;
    end
  end

  // sel_pin_e_a and fast registers are not strap loaded
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel_pin_e_a_q <= 8'h00;
      fast_q <= 8'h00;
    end
    else if (wr_ok && i_config_index == `RCR_IDX_SEL_PIN_E_A)
      sel_pin_e_a_q <= i_cfg_wdata;
    else if (wr_ok && i_config_index == `RCR_IDX_FAST)
      fast_q <= i_cfg_wdata & `RCR_MASK_FAST;
  end

  // a strap reload in the same cycle as a write wins over the write
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fdc_q <= 8'h00;
      prt_q <= 8'h00;
      ua_q <= 8'h00;
      ub_q <= 8'h00;
      dma_q <= 8'h00;
      pirq_q <= 8'h00;
    end
    else if (load_dflt)
    begin
      fdc_q <= dflt(i_config_default_strap, `RCR_DFLT_FDC);
      prt_q <= dflt(i_config_default_strap, `RCR_DFLT_PRT);
      ua_q <= dflt(i_config_default_strap, `RCR_DFLT_UA);
      ub_q <= dflt(i_config_default_strap, `RCR_DFLT_UB);
      dma_q <= dflt(i_config_default_strap, `RCR_DFLT_DMA);
      pirq_q <= dflt(i_config_default_strap, `RCR_DFLT_PIRQ);
    end
    else if (wr_ok)
    begin
      case (i_config_index)
        `RCR_IDX_FDC: fdc_q <= i_cfg_wdata & `RCR_MASK_FDC;
        `RCR_IDX_PRT: prt_q <= i_cfg_wdata;
        `RCR_IDX_UA: ua_q <= i_cfg_wdata & `RCR_MASK_UART;
        `RCR_IDX_UB: ub_q <= i_cfg_wdata & `RCR_MASK_UART;
        `RCR_IDX_DMA: dma_q <= i_cfg_wdata;
        `RCR_IDX_PIRQ: pirq_q <= i_cfg_wdata & `RCR_MASK_PIRQ;
        default: ;
      endcase
    end
  end

  // read data is registered; outside extended mode or at other indices it reads zero
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_cfg_rdata <= 8'h00;
    else if (!i_ext_func_mode)
      o_cfg_rdata <= 8'h00;
    else
    begin
      case (i_config_index)
        `RCR_IDX_SEL_PIN_E_A: o_cfg_rdata <= sel_pin_e_a_q;
        `RCR_IDX_FAST: o_cfg_rdata <= fast_q;
        `RCR_IDX_FDC: o_cfg_rdata <= fdc_q;
        `RCR_IDX_PRT: o_cfg_rdata <= prt_q;
        `RCR_IDX_UA: o_cfg_rdata <= ua_q;
        `RCR_IDX_UB: o_cfg_rdata <= ub_q;
        `RCR_IDX_DMA: o_cfg_rdata <= dma_q;
        `RCR_IDX_PIRQ: o_cfg_rdata <= pirq_q;
        default: o_cfg_rdata <= 8'h00;
      endcase
    end
  end

  // base decoders
  assign o_floppy_sel = base_on(fdc_q) && !i_chip_select_n && !i_addr[10]
    && i_addr[9:4] == fdc_q[7:2] && !i_addr[3];
  // in extended-capability mode A10 selects the upper register set, so both halves decode
  assign o_printer_sel = base_on(prt_q) && !i_chip_select_n
    && (i_ecp_mode || !i_addr[10]) && i_addr[9:2] == prt_q;
  assign o_serial_a_sel = base_on(ua_q) && !i_chip_select_n && !i_addr[10]
    && i_addr[9:3] == ua_q[7:1];
  assign o_serial_b_sel = base_on(ub_q) && !i_chip_select_n && !i_addr[10]
    && i_addr[9:3] == ub_q[7:1];

  assign o_serial_a_clk_src = clk_src(fast_q[`RCR_FAST_A_BIT], i_serial_a_speed_sel,
                                      i_serial_a_music_clk);
  assign o_serial_b_clk_src = clk_src(fast_q[`RCR_FAST_B_BIT], i_serial_b_speed_sel,
                                      i_serial_b_music_clk);

  assign o_floppy_dma_sel = dma_dec(dma_q[7:4]);
  assign o_printer_dma_sel = dma_dec(dma_q[3:0]);

  assign o_ext_cap_config_b = pirq_q[7:5];
  always_comb
  begin
    case (pirq_q[7:5])
      3'h1: o_ext_cap_irq_num = 4'h7;
      3'h2: o_ext_cap_irq_num = 4'h9;
      3'h3: o_ext_cap_irq_num = 4'hA;
      3'h4: o_ext_cap_irq_num = 4'hB;
      3'h5: o_ext_cap_irq_num = 4'hE;
      3'h6: o_ext_cap_irq_num = 4'hF;
      3'h7: o_ext_cap_irq_num = 4'h5;
      default: o_ext_cap_irq_num = 4'h0;
    endcase
  end

  // interrupt pin routing
  assign pin_valid = !i_serial_interrupt_mode && pirq_q[3:0] != 4'h0 && pirq_q[3:0] <= 4'h8;
  assign pin_idx = 3'(pirq_q[3:0] - 4'h1);
  assign pulse_start = pin_valid && sel_pin_e_a_q[pin_idx] && i_printer_irq && !irq_prev_q;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_prev_q <= 1'b0;
    else
      irq_prev_q <= i_printer_irq;
  end

  // a new request edge retriggers the full pulse
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pulse_cnt_q <= 2'h0;
    else if (pulse_start)
      pulse_cnt_q <= 2'(PULSE_CYC);
    else if (pulse_cnt_q != 2'h0)
      pulse_cnt_q <= pulse_cnt_q - 2'h1;
  end

  always_comb
  begin
    o_irq_pin_out = 8'h00;
    o_irq_pin_oe = 8'h00;
    if (pin_valid)
    begin
      if (sel_pin_e_a_q[pin_idx])
        o_irq_pin_oe[pin_idx] = pulse_cnt_q != 2'h0;
      else
      begin
        o_irq_pin_oe[pin_idx] = 1'b1;
        o_irq_pin_out[pin_idx] = i_printer_irq;
      end
    end
  end

  assign o_serial_irq_frame = i_serial_interrupt_mode ? pirq_q[3:0] : 4'h0;
  assign o_serial_irq_req = i_serial_interrupt_mode && i_printer_irq
    && pirq_q[3:0] != 4'h0 && pirq_q[3:0] != `RCR_SER_FRAME_SMI;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  write_gate_a: assert property (!i_ext_func_mode ##1 1 |->
    $stable({sel_pin_e_a_q, fast_q, fdc_q, prt_q, ua_q, ub_q, dma_q, pirq_q}) || $past(load_dflt))
    else $error("register changed outside extended mode");
  fast_read_a: assert property (i_ext_func_mode && i_config_index == `RCR_IDX_FAST
    |=> o_cfg_rdata[7:2] == 6'h00)
    else $error("reserved fast bits read nonzero");
  sel_pin_e_a_pulse_a: assert property (pulse_start |=>
    (|o_irq_pin_oe && o_irq_pin_out == 8'h00)[*2])
    else $error("sharing pulse too short");
  fast_src_a: assert property (fast_q[1] |-> o_serial_a_clk_src == RCR_SRC_FAST)
    else $error("serial A not on fast clock");
  fdc_off_a: assert property (fdc_q[7:6] == 2'h0 |-> !o_floppy_sel)
    else $error("floppy decode active while disabled");
  fdc_a10_a: assert property (i_addr[10] || i_chip_select_n |-> !o_floppy_sel)
    else $error("floppy decode ignores A10 or chip select");
  serial_tri_a: assert property (i_serial_interrupt_mode |-> o_irq_pin_oe == 8'h00)
    else $error("pin driven in serial mode");
  strap_reload_a: assert property (init_q && i_config_default_strap != strap_q
    |=> fdc_q == ($past(i_config_default_strap) ? `RCR_DFLT_FDC : 8'h00))
    else $error("strap flip did not reload");
  unsel_tri_a: assert property (pirq_q[3:0] == 4'h0 |-> o_irq_pin_oe == 8'h00)
    else $error("pin driven with no selection");
  cfgb_copy_a: assert property (i_ext_func_mode && i_config_index == `RCR_IDX_PIRQ
    |=> o_cfg_rdata[4] == 1'b0 && o_cfg_rdata[7:5] == $past(o_ext_cap_config_b))
    else $error("config B copy wrong");

  sel_pin_e_a_pulse_c: cover property (pulse_start ##3 o_irq_pin_oe == 8'h00);
  serial_req_c: cover property (o_serial_irq_req);
  strap_flip_c: cover property (init_q && i_config_default_strap != strap_q);
  fdc_hit_c: cover property (o_floppy_sel);

endmodule : rcr_regs

/* tb/rcr_irq_host.sv */
`timescale 1ns/10ps
// host side of the interrupt pins: lines are pulled up, so a released pin reads high
module rcr_irq_host (
  // pins from the device
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  // resolved line levels
  output logic [7:0] o_line
);
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      o_line[k] = i_pin_oe[k] ? i_pin_out[k] : 1'b1;
    end
  end
endmodule : rcr_irq_host

/* tb/resource_config_regs_tb.sv */
`timescale 1ns/10ps
`include "rcr_cfg.svh"
module resource_config_regs_tb;
  import rcr_pkg::*;
  localparam int PC = 2;
  logic i_clock = 0;
  logic i_reset_n = 0;
  logic mode = 0, wr = 0, strap = 1, ecp = 0, irq = 0, smode = 0, cs_n = 1;
  logic [7:0] idx = 0, wd = 0, rdata, oe, pout, line;
  logic [10:0] addr = 0;
  logic [3:0] spd = 0, frame, irqn;
  logic fs, ps, sas, sbs, sreq;
  rcr_clk_src_t csa, csb;
  logic [2:0] fdma, pdma, cfgb;
  logic [31:0] seed = 32'hA0616814;
  int n_errors = 0, total_checks = 0, cnt;
  logic [7:0] ix [8] = '{8'h18, 8'h19, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [7:0] dflt [8] = '{8'h00, 8'h00, `RCR_DFLT_FDC, `RCR_DFLT_PRT, `RCR_DFLT_UA,
    `RCR_DFLT_UB, `RCR_DFLT_DMA, `RCR_DFLT_PIRQ};
  logic [3:0] irq_tbl [8] = '{4'h0, 4'h7, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF, 4'h5};

  always #50 i_clock = ~i_clock;

  rcr_regs #(.PULSE_CYC(PC)) DUT (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_ext_func_mode(mode), .i_config_index(idx), .i_cfg_wr(wr), .i_cfg_wdata(wd),
    .o_cfg_rdata(rdata), .i_config_default_strap(strap), .i_addr(addr),
    .i_chip_select_n(cs_n), .i_ecp_mode(ecp), .o_floppy_sel(fs), .o_printer_sel(ps),
    .o_serial_a_sel(sas), .o_serial_b_sel(sbs), .i_serial_a_speed_sel(spd[0]),
    .i_serial_a_music_clk(spd[1]), .i_serial_b_speed_sel(spd[2]),
    .i_serial_b_music_clk(spd[3]), .o_serial_a_clk_src(csa), .o_serial_b_clk_src(csb),
    .o_floppy_dma_sel(fdma), .o_printer_dma_sel(pdma), .i_printer_irq(irq),
    .i_serial_interrupt_mode(smode), .o_irq_pin_out(pout), .o_irq_pin_oe(oe),
    .o_serial_irq_req(sreq), .o_serial_irq_frame(frame), .o_ext_cap_config_b(cfgb),
    .o_ext_cap_irq_num(irqn));

  rcr_irq_host HOST (.i_pin_out(pout), .i_pin_oe(oe), .o_line(line));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      8'h19: return `RCR_MASK_FAST;
      8'h20: return `RCR_MASK_FDC;
      8'h24, 8'h25: return `RCR_MASK_UART;
      8'h27: return `RCR_MASK_PIRQ;
      default: return 8'hFF;
    endcase
  endfunction : msk

  // priority fast over music over speed
  function automatic logic [7:0] src(input logic f, input logic m, input logic s);
    return f ? 8'(RCR_SRC_FAST) : m ? 8'(RCR_SRC_MUSIC) : s ? 8'(RCR_SRC_SPEED) : 8'h00;
  endfunction : src

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    @(negedge i_clock);
    idx = i;
    wd = d;
    wr = 1;
    @(negedge i_clock);
    wr = 0;
  endtask : wreg

  // rdata is registered, so look one edge after the index is set
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    @(negedge i_clock);
    idx = i;
    @(negedge i_clock);
    chk(rdata, e);
  endtask : rreg

  task automatic dec(input logic c, input logic e, input logic [10:0] a, input logic [3:0] x);
    @(negedge i_clock);
    cs_n = c;
    ecp = e;
    addr = a;
    @(negedge i_clock);
    chk({4'h0, fs, ps, sas, sbs}, {4'h0, x});
  endtask : dec

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
    end_of_test();
  end

  initial
  begin
    repeat (5) @(negedge i_clock);
    i_reset_n = 1;
    mode = 1;
    for (int k = 0; k < 8; k++) rreg(ix[k], dflt[k]);
    $display("test defaults done");
    dec(0, 0, 11'h3F0, 4'b1000);
    dec(0, 0, 11'h3F8, 4'b0010);
    dec(0, 0, 11'h7F8, 4'b0000);
    dec(0, 0, 11'h37A, 4'b0100);
    dec(0, 0, 11'h77A, 4'b0000);
    dec(0, 1, 11'h77A, 4'b0100);
    dec(0, 0, 11'h2FF, 4'b0001);
    dec(1, 0, 11'h3F0, 4'b0000);
    wreg(8'h20, 8'h3C);
    dec(0, 0, 11'h0F0, 4'b0000);
    $display("test decode done");
    for (int k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      wreg(ix[k % 8], seed[7:0]);
      rreg(ix[k % 8], seed[7:0] & msk(ix[k % 8]));
    end
    wreg(8'h26, 8'h21);
    mode = 0;
    wreg(8'h26, 8'h12);
    rreg(8'h26, 8'h00);
    mode = 1;
    rreg(8'h26, 8'h21);
    rreg(8'h21, 8'h00);
    $display("test access done");
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h26, {4'(c), 4'(c)});
      chk({5'h0, fdma}, c == 0 ? 8'h00 : 8'h01 << (c - 1));
      chk({5'h0, pdma}, c == 0 ? 8'h00 : 8'h01 << (c - 1));
    end
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      spd = seed[3:0];
      wreg(8'h19, 8'(k % 4));
      chk({6'h0, csa}, src(k[1], spd[1], spd[0]));
      chk({6'h0, csb}, src(k[0], spd[3], spd[2]));
    end
    $display("test dma and clock done");
    wreg(8'h18, 8'h00);
    for (int p = 1; p < 9; p++)
    begin
      seed = xs(seed);
      wreg(8'h27, {3'(p - 1), 1'b0, 4'(p)});
      irq = seed[0];
      @(negedge i_clock);
      chk(oe, 8'h01 << (p - 1));
      chk(line, ~(8'h01 << (p - 1)) | (8'(irq) << (p - 1)));
      chk({5'h0, cfgb}, 8'(p - 1));
      chk({4'h0, irqn}, {4'h0, irq_tbl[p - 1]});
    end
    irq = 0;
    wreg(8'h18, 8'h10);
    wreg(8'h27, 8'h05);
    @(negedge i_clock);
    irq = 1;
    cnt = 0;
    repeat (10) @(negedge i_clock) if (line[4] === 1'b0) cnt++;
    chk(8'(cnt), 8'(PC));
    chk(line, 8'hFF);
    $display("test irq pins done");
    smode = 1;
    for (int f = 0; f < 16; f++)
    begin
      seed = xs(seed);
      irq = seed[0];
      wreg(8'h27, 8'(f));
      chk(oe, 8'h00);
      chk({4'h0, frame}, 8'(f));
      chk({7'h0, sreq}, {7'h0, irq && f != 0 && f != 2});
    end
    smode = 0;
    $display("test serial irq done");
    strap = 0;
    for (int k = 2; k < 8; k++) rreg(ix[k], 8'h00);
    wreg(8'h26, 8'h11);
    rreg(8'h26, 8'h11);
    strap = 1;
    for (int k = 2; k < 8; k++) rreg(ix[k], dflt[k]);
    $display("test strap done");
    i_reset_n = 0;
    repeat (2) @(negedge i_clock);
    i_reset_n = 1;
    for (int k = 0; k < 8; k++) rreg(ix[k], dflt[k]);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : resource_config_regs_tb
